// [shared/exec_map.vh]
// constants for the rotate, subtract and sleep execution block
`ifndef EXEC_MAP_VH
`define EXEC_MAP_VH
`define OP_NONE 3'h0
`define OP_ROT_LEFT 3'h1
`define OP_ROT_RIGHT 3'h2
`define OP_LIT_SUB 3'h3
`define OP_REG_SUB 3'h4
`define OP_SLEEP 3'h5
`define DEST_ACC 1'h0
`define DEST_FILE 1'h1
`define FILE_ADDR_MAX 7'h7f
`define ACC_RST 8'h00
`define CARRY_RST 1'h0
`define NIBBLE_RST 1'h0
`define ZERO_RST 1'h0
`define TIMEOUT_RST 1'h1
`define PDOWN_RST 1'h1
`define WDOG_ZERO 8'h00
`define PRESC_ZERO 8'h00
`define OSC_RST 1'h1
`define WE_RST 1'h0
`define WADDR_RST 7'h00
`define WDATA_RST 8'h00
`define WCLR_RST 1'h0
`define PRESC_WRAP 8'hff
`endif

// [verilog/sub_unit.v]
// 8-bit a minus b by two's complement with carry and nibble borrow flags
`timescale 1ns/100ps
`default_nettype none
module sub_unit (
  // operands
  input wire [7:0] a,
  input wire [7:0] b,
  // result and flags
  output wire [7:0] diff,
  output wire carry,
  output wire nibble,
  output wire zero
);
  wire [8:0] full;
  wire [4:0] low;
  // carry set means no borrow
  assign full = {1'h0, a} + {1'h0, ~b} + 9'h001;
  assign low = {1'h0, a[3:0]} + {1'h0, ~b[3:0]} + 5'h01;
  assign diff = full[7:0];
  assign carry = full[8];
  assign nibble = low[4];
  assign zero = (full[7:0] == 8'h00);
endmodule
`default_nettype wire

// [verilog/exec_core.v]
// execution logic for rotate, subtract and sleep instructions
// How it works
// - file operand is a 7-bit address 0..127; destination select 0 or 1
// - select 0 writes accumulator, select 1 writes back the addressed file register
// - rotate left: old carry into bit 0, bit 7 to carry; only carry changes
// - rotate right: old carry into bit 7, bit 0 to carry; only carry changes
// - sleep zeroes the watchdog counter and its prescaler
// - sleep sets timeout flag to 1 and clears power-down flag
// - after sleep the core idles with the oscillator halted
// - literal minus accumulator into accumulator, updating carry, nibble and zero
// - literal subtract: carry and nibble bit clear only on borrow
// - register minus accumulator to selected destination, updating three flags
// - register subtract: carry and nibble bit clear only on borrow
`timescale 1ns/100ps
`default_nettype none
`include "exec_map.vh"
module exec_core (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // decoded instruction
  input wire [2:0] op,
  input wire op_valid,
  input wire [6:0] file_addr,
  input wire dest_sel,
  input wire [7:0] literal,
  // file register read data for file_addr, same cycle
  input wire [7:0] file_rdata,
  // file register write back
  output reg file_we,
  output reg [6:0] file_waddr,
  output reg [7:0] file_wdata,
  // accumulator and status
  output wire [7:0] accumulator,
  output wire carry_flag,
  output wire nibble_ripple_bit,
  output wire zero_flag,
  output wire timeout_flag,
  output wire power_down_flag,
  // watchdog clear and sleep state
  output reg watchdog_clear,
  output wire [7:0] watchdog_counter,
  output wire [7:0] prescaler,
  output wire sleeping,
  output wire osc_enable
);
  // run or sleep state codes
  localparam ST_RUN = 1'h0;
  localparam ST_SLEEP = 1'h1;
  // instruction decode; a sleeping core ignores instructions
  wire run;
  wire is_rot_left;
  wire is_rot_right;
  wire is_lit_sub;
  wire is_reg_sub;
  wire is_sleep;
  wire is_rotate;
  wire is_subtract;
  wire dest_is_file;
  // accumulator and arithmetic flags
  reg [7:0] acc_q;
  reg [7:0] acc_d;
  reg c_q;
  reg c_d;
  reg nib_q;
  reg nib_d;
  reg z_q;
  reg z_d;
  // sleep status flags
  reg tmo_q;
  reg tmo_d;
  reg pdn_q;
  reg pdn_d;
  // run or sleep state and oscillator gate
  reg st_q;
  reg st_d;
  reg osc_q;
  reg osc_d;
  // watchdog model
  reg [7:0] wdog_q;
  reg [7:0] wdog_d;
  reg [7:0] pre_q;
  reg [7:0] pre_d;
  reg wclr_d;
  // file register write port
  reg we_d;
  reg [6:0] wa_d;
  reg [7:0] wd_d;
  // result path
  reg [7:0] rot_res;
  reg rot_carry;
  reg [7:0] res;
  reg [7:0] sub_a;
  wire [7:0] sub_diff;
  wire sub_carry;
  wire sub_nib;
  wire sub_zero;

  assign run = op_valid && (st_q == ST_RUN);
  assign is_rot_left = run && (op == `OP_ROT_LEFT);
  assign is_rot_right = run && (op == `OP_ROT_RIGHT);
  assign is_lit_sub = run && (op == `OP_LIT_SUB);
  assign is_reg_sub = run && (op == `OP_REG_SUB);
  assign is_sleep = run && (op == `OP_SLEEP);
  assign is_rotate = is_rot_left || is_rot_right;
  assign is_subtract = is_lit_sub || is_reg_sub;
  assign dest_is_file = (dest_sel == `DEST_FILE);

  // one subtractor shared by both subtract forms
  sub_unit u_sub (
    .a(sub_a),
    .b(acc_q),
    .diff(sub_diff),
    .carry(sub_carry),
    .nibble(sub_nib),
    .zero(sub_zero)
  );

  always @* begin
    if (is_lit_sub) begin
      sub_a = literal;
    end else begin
      sub_a = file_rdata;
    end
  end

  // rotate through carry
  always @* begin
    rot_res = file_rdata;
    rot_carry = c_q;
    if (is_rot_left) begin
      rot_res = {file_rdata[6:0], c_q};
      rot_carry = file_rdata[7];
    end else if (is_rot_right) begin
      rot_res = {c_q, file_rdata[7:1]};
      rot_carry = file_rdata[0];
    end
  end

  always @* begin
    if (is_rotate) begin
      res = rot_res;
    end else begin
      res = sub_diff;
    end
  end

  // accumulator takes literal results and file-form results with select 0
  always @* begin
    acc_d = acc_q;
    if (is_lit_sub) begin
      acc_d = sub_diff;
    end else if ((is_rotate || is_reg_sub) && !dest_is_file) begin
      acc_d = res;
    end
  end

  // carry is the only flag a rotate touches
  always @* begin
    c_d = c_q;
    if (is_rotate) begin
      c_d = rot_carry;
    end else if (is_lit_sub) begin
      c_d = sub_carry;
    end else if (is_reg_sub) begin
      c_d = sub_carry;
    end
  end

  always @* begin
    nib_d = nib_q;
    if (is_lit_sub) begin
      nib_d = sub_nib;
    end else if (is_reg_sub) begin
      nib_d = sub_nib;
    end
  end

  always @* begin
    z_d = z_q;
    if (is_subtract) begin
      z_d = sub_zero;
    end
  end

  always @* begin
    tmo_d = tmo_q;
    pdn_d = pdn_q;
    if (is_sleep) begin
      tmo_d = 1'h1;
      pdn_d = 1'h0;
    end
  end

  // only reset leaves sleep; wake-up sources live outside this block
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_RUN: begin
        if (is_sleep) begin
          st_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        st_d = ST_SLEEP;
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  // gate from a flop so the oscillator stop carries no glitch
  always @* begin
    osc_d = (st_d == ST_RUN);
  end

  // counter freezes in sleep; a real wake timer would keep running
  always @* begin
    pre_d = pre_q;
    wdog_d = wdog_q;
    wclr_d = 1'h0;
    if (is_sleep) begin
      pre_d = `PRESC_ZERO;
      wdog_d = `WDOG_ZERO;
      wclr_d = 1'h1;
    end else if (st_q == ST_RUN) begin
      pre_d = pre_q + 8'h01;
      if (pre_q == `PRESC_WRAP) begin
        wdog_d = wdog_q + 8'h01;
      end
    end
  end

  // write data holds between writes to save toggling
  always @* begin
    we_d = 1'h0;
    wa_d = file_addr;
    wd_d = file_wdata;
    if ((is_rotate || is_reg_sub) && dest_is_file) begin
      we_d = 1'h1;
      wd_d = res;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acc_q <= `ACC_RST;
      c_q <= `CARRY_RST;
      nib_q <= `NIBBLE_RST;
      z_q <= `ZERO_RST;
    end else begin
      acc_q <= acc_d;
      c_q <= c_d;
      nib_q <= nib_d;
      z_q <= z_d;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tmo_q <= `TIMEOUT_RST;
      pdn_q <= `PDOWN_RST;
    end else begin
      tmo_q <= tmo_d;
      pdn_q <= pdn_d;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_RUN;
      osc_q <= `OSC_RST;
    end else begin
      st_q <= st_d;
      osc_q <= osc_d;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wdog_q <= `WDOG_ZERO;
      pre_q <= `PRESC_ZERO;
      watchdog_clear <= `WCLR_RST;
    end else begin
      wdog_q <= wdog_d;
      pre_q <= pre_d;
      watchdog_clear <= wclr_d;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      file_we <= `WE_RST;
      file_waddr <= `WADDR_RST;
      file_wdata <= `WDATA_RST;
    end else begin
      file_we <= we_d;
      file_waddr <= wa_d;
      file_wdata <= wd_d;
    end
  end

  assign accumulator = acc_q;
  assign carry_flag = c_q;
  assign nibble_ripple_bit = nib_q;
  assign zero_flag = z_q;
  assign timeout_flag = tmo_q;
  assign power_down_flag = pdn_q;
  assign watchdog_counter = wdog_q;
  assign prescaler = pre_q;
  assign sleeping = (st_q == ST_SLEEP);
  assign osc_enable = osc_q;
endmodule
`default_nettype wire

// [dv/exec_core_sva.sv]
// bound checker for exec_core
`timescale 1ns/100ps
`default_nettype none
module exec_core_sva (
  // inputs
  input wire mclk,
  input wire rstn,
  input wire [2:0] op,
  input wire op_valid,
  input wire dest_sel,
  input wire [7:0] literal,
  input wire [7:0] file_rdata,
  // outputs
  input wire file_we,
  input wire [7:0] accumulator,
  input wire carry_flag,
  input wire nibble_ripple_bit,
  input wire zero_flag,
  input wire timeout_flag,
  input wire power_down_flag,
  input wire watchdog_clear,
  input wire sleeping,
  input wire osc_enable
);
  // ops while asleep are dropped, so they must not trip anything
  wire go = op_valid && !sleeping;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  rol_carry_a: assert property (go&&op==3'h1 |=> carry_flag==$past(file_rdata[7])) else $error("rol");
  ror_carry_a: assert property (go&&op==3'h2 |=> carry_flag==$past(file_rdata[0])) else $error("ror");
  dest_we_a: assert property (go&&op==3'h4 |=> file_we==$past(dest_sel)) else $error("we");
  sub_diff_a: assert property (go&&op==3'h4&&!dest_sel |=> accumulator==$past(file_rdata)-$past(accumulator))
    else $error("sub");
  sub_carry_a: assert property (go&&op==3'h4 |=> carry_flag==($past(accumulator)<=$past(file_rdata)))
    else $error("c");
  lit_sub_a: assert property (go&&op==3'h3 |=> accumulator==$past(literal)-$past(accumulator))
    else $error("lsub");
  lit_flags_a: assert property (go&&op==3'h3 |=> carry_flag==($past(accumulator)<=$past(literal))
    && nibble_ripple_bit==($past(accumulator[3:0])<=$past(literal[3:0]))) else $error("lflags");
  sub_zero_a: assert property (go&&op==3'h4 |=> zero_flag==($past(file_rdata)==$past(accumulator)))
    else $error("z");
  wd_clear_a: assert property (go&&op==3'h5 |=> watchdog_clear ##1 !watchdog_clear) else $error("wd");
  sleep_flags_a: assert property (go&&op==3'h5 |=> timeout_flag&&!power_down_flag) else $error("flags");
  osc_stop_a: assert property (go&&op==3'h5 |=> sleeping&&!osc_enable ##1 !osc_enable) else $error("osc");
  cover property (go&&op==3'h4&&dest_sel);
  cover property (go&&op==3'h5);
  cover property (go&&op==3'h1);
endmodule
bind exec_core exec_core_sva u_sva (
  .mclk(mclk),
  .rstn(rstn),
  .op(op),
  .op_valid(op_valid),
  .dest_sel(dest_sel),
  .literal(literal),
  .file_rdata(file_rdata),
  .file_we(file_we),
  .accumulator(accumulator),
  .carry_flag(carry_flag),
  .nibble_ripple_bit(nibble_ripple_bit),
  .zero_flag(zero_flag),
  .timeout_flag(timeout_flag),
  .power_down_flag(power_down_flag),
  .watchdog_clear(watchdog_clear),
  .sleeping(sleeping),
  .osc_enable(osc_enable)
);
`default_nettype wire

// [dv/rotate_subtract_sleep_exec_test.sv]
// self-checking bench for exec_core
`timescale 1ns/100ps
`default_nettype none
`define chk(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    n_fail++; \
    $display("wrong value at %0t: got %0h want %0h", $time, (a), (b)); \
  end \
end
module rotate_subtract_sleep_exec_test;
  logic mclk = 1'h0, rstn = 1'h0, op_valid = 1'h0, dest_sel = 1'h0, file_we, carry_flag, zero_flag;
  logic nibble_ripple_bit, timeout_flag, power_down_flag, watchdog_clear, sleeping, osc_enable;
  logic [2:0] op = 3'h0;
  logic [6:0] file_addr = 7'h7f, file_waddr;
  logic [7:0] literal = 8'h00, file_rdata = 8'h00, file_wdata, accumulator, watchdog_counter, prescaler;
  int n_fail = 0, samples_checked = 0;
  exec_core u_exec_core (
    .mclk(mclk),
    .rstn(rstn),
    .op(op),
    .op_valid(op_valid),
    .file_addr(file_addr),
    .dest_sel(dest_sel),
    .literal(literal),
    .file_rdata(file_rdata),
    .file_we(file_we),
    .file_waddr(file_waddr),
    .file_wdata(file_wdata),
    .accumulator(accumulator),
    .carry_flag(carry_flag),
    .nibble_ripple_bit(nibble_ripple_bit),
    .zero_flag(zero_flag),
    .timeout_flag(timeout_flag),
    .power_down_flag(power_down_flag),
    .watchdog_clear(watchdog_clear),
    .watchdog_counter(watchdog_counter),
    .prescaler(prescaler),
    .sleeping(sleeping),
    .osc_enable(osc_enable)
  );
  initial forever #25 mclk = ~mclk;
  initial begin
    repeat (500) @(posedge mclk);
    n_fail++;
    complete_run;
  end
  task complete_run;
    $display("%0d checks %0d fails", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // file data and file address reuse the literal
  task ex(input logic [2:0] o, input logic d, input logic [7:0] k);
    @(posedge mclk);
    {op, op_valid, dest_sel, literal, file_rdata, file_addr} <= {o, 1'h1, d, k, k, k[6:0]};
    @(posedge mclk);
    op_valid <= 1'h0;
    #1;
  endtask
  task t_rot;
    ex(3'h1, 1'h1, 8'he6);
    `chk({file_we, file_waddr, file_wdata, carry_flag}, 17'h1cd99)
    ex(3'h2, 1'h0, 8'h01);
    `chk({accumulator, carry_flag}, 9'h101)
    // unused opcode must leave everything alone
    ex(3'h6, 1'h1, 8'h55);
    `chk({file_we, accumulator, carry_flag}, 10'h101)
  endtask
  task t_sub;
    ex(3'h3, 1'h0, 8'h05);
    `chk({accumulator, carry_flag, nibble_ripple_bit, zero_flag}, 11'h42a)
    ex(3'h4, 1'h0, 8'h13);
    `chk({accumulator, carry_flag, nibble_ripple_bit}, 10'h238)
    ex(3'h4, 1'h1, 8'h8e);
    `chk({file_we, file_waddr, file_wdata, carry_flag, zero_flag}, 18'h23803)
  endtask
  task t_sleep;
    // let the prescaler wrap so the clear has something to clear
    repeat (300) @(posedge mclk);
    #1;
    `chk(watchdog_counter != 8'h00, 1'h1)
    ex(3'h5, 1'h0, 8'h00);
    `chk({watchdog_counter, prescaler, watchdog_clear}, 17'h00001)
    `chk({timeout_flag, power_down_flag, sleeping, osc_enable}, 4'ha)
    ex(3'h1, 1'h0, 8'hff);
    `chk({osc_enable, accumulator, watchdog_clear, carry_flag}, 11'h239)
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'h1;
    t_rot;
    t_sub;
    t_sleep;
    complete_run;
  end
endmodule
`default_nettype wire
